/* src/hsit_fs_edge.sv */
// Frame-sync pin synchroniser and active-edge detector
`timescale 1ns/1ps
`default_nettype none

module hsit_fs_edge (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic frame_sync_i,
  input  wire logic edge_sel_i,
  output logic      fs_level_o,
  output logic      fs_edge_o
);

  logic       meta_q;
  logic [1:0] sync_q;
  logic       level_q;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage capture; the first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 2'b00;
    end else begin
      meta_q <= frame_sync_i;
      sync_q <= {sync_q[0], meta_q};
    end
  end

  // Accept a new level only once stages two and three agree
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b0;
    end else if (sync_q[0] == sync_q[1]) begin
      level_q <= sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active edge: rising when select is low, falling when high
  always_comb begin
    fs_edge_o = 1'b0;
    if (sync_q[0] == sync_q[1] && sync_q[1] != level_q) begin
      fs_edge_o = edge_sel_i ? level_q : sync_q[1];
    end
  end

  assign fs_level_o = level_q;

endmodule // hsit_fs_edge

`default_nettype wire

/* src/hsit_pkg.sv */
// Package: offsets, field layout, reset values and timing of the hub register bank
package hsit_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FORWARD_SYNC_STATUS   = 8'h22;
  localparam logic [7:0] ADDR_IRQ_CTL   = 8'h23;
  localparam logic [7:0] ADDR_IRQ_STS   = 8'h24;
  localparam logic [7:0] ADDR_TS_CFG    = 8'h25;
  localparam logic [7:0] ADDR_FWD_MODE  = 8'h30;
  localparam logic [7:0] ADDR_EVT_STS   = 8'h31;
  localparam logic [7:0] ADDR_EVT_MASK  = 8'h32;

  // Reset values
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] RST_SYNC_SEL   = 2'h0;

  // Field positions in forward_sync_status
  localparam int FWD_LOCKED_BIT = 0;
  localparam int FWD_LOSS_BIT   = 2;

  // Field positions in irq_enable_control / irq_pending_status
  localparam int IRQ_TX_BIT     = 4;
  localparam int IRQ_GLOBAL_BIT = 7;
  localparam logic [7:0] IRQ_CTL_WMASK = 8'h9F;

  // Field positions in timestamp_config
  localparam int TS_EDGE_BIT    = 6;
  localparam int TS_RES_LSB     = 4;
  localparam int TS_EARLY_BIT   = 3;
  localparam int TS_FREE_BIT    = 1;
  localparam int TS_POINT_BIT   = 0;
  localparam logic [7:0] TS_CFG_WMASK = 8'h7B;

  // Hub event bits (sticky, write one to clear)
  localparam int EVT_LOSS_BIT   = 0;
  localparam int EVT_LOCK_BIT   = 1;
  localparam int EVT_READY_BIT  = 2;
  localparam int EVT_FS_BIT     = 3;
  localparam int EVT_NUM        = 4;

  // Tick resolution codes
  typedef enum logic [1:0] {
    HSIT_RES_40NS,
    HSIT_RES_80NS,
    HSIT_RES_160NS,
    HSIT_RES_1US
  } hsit_res_t;

  // Clock period and tick periods, in ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_40_NS    = 40;
  localparam int TICK_80_NS    = 80;
  localparam int TICK_160_NS   = 160;
  localparam int TICK_1000_NS  = 1000;

  // Tick periods in clock cycles
  localparam logic [7:0] TICK_40_CYC   = 8'(TICK_40_NS / CLK_PERIOD_NS);
  localparam logic [7:0] TICK_80_CYC   = 8'(TICK_80_NS / CLK_PERIOD_NS);
  localparam logic [7:0] TICK_160_CYC  = 8'(TICK_160_NS / CLK_PERIOD_NS);
  localparam logic [7:0] TICK_1000_CYC = 8'(TICK_1000_NS / CLK_PERIOD_NS);

endpackage

/* src/hsit_regs.sv */
// Hub status, interrupt aggregation and timestamp configuration registers
//
// Overview of operation
// - Loss flag sets on sync loss only after one synced frame went out.
// - Reading the forwarding status register clears the loss flag.
// - Lock bit follows engine sync state, zero when forwarding sync is off.
// - Interrupt output high only with global enable and global pending.
// - Enable bits: transmit port at bit 4, receive ports 3..0 at bits 3..0.
// - Global pending is any source status with its enable or hub event with its mask, ignoring global enable.
// - Reading the transmit port event register clears its source bit.
// - Reading a receive port's event registers clears that port's source bit.
// - Frame sync active on rising edge for select 0, falling for 1.
// - Tick resolution code 00/01/10/11 gives 40 ns/80 ns/160 ns/1.0 us.
// - Early-ready bit reports ready once every port timestamp is available.
// - Free-run bit 0 gives frame-sync capture, 1 gives free-run capture.
// - Capture point bit 0 is line start, 1 is frame start.
// - Forwarding sync enabled when the select field is nonzero.
`timescale 1ns/1ps
`default_nettype none

module hsit_regs
  import hsit_pkg::*;
#(
  parameter int NUM_RX = 4
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Forwarding engine
  input  wire logic              fwd_frame_sent_i,
  input  wire logic              fwd_sync_ok_i,
  input  wire logic              fwd_sync_lost_i,
  output logic      [1:0]        sync_forward_select_o,
  // Interrupt sources and their clears
  input  wire logic              tx_port_irq_i,
  input  wire logic              tx_port_event_read_i,
  input  wire logic [NUM_RX-1:0] rx_port_irq_i,
  input  wire logic [NUM_RX-1:0] rx_port_event_read_i,
  output logic                   irq_o,
  // Timestamp unit
  input  wire logic              frame_sync_i,
  input  wire logic              line_start_i,
  input  wire logic              frame_start_i,
  input  wire logic [NUM_RX-1:0] stamp_port_avail_i,
  input  wire logic              stamp_normal_ready_i,
  output logic                   stamp_tick_o,
  output logic                   stamp_capture_o,
  output logic                   stamp_ready_o,
  output logic                   stamp_free_run_select_o,
  output logic                   stamp_capture_point_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sticky flag update; a set in the clearing cycle wins
  function automatic logic sticky(input logic q, input logic set, input logic clr);
    return set | (q & ~clr);
  endfunction

  // Cycle count of one timestamp tick for a resolution code
  function automatic logic [7:0] tick_cycles(input hsit_res_t res);
    logic [7:0] cyc;
    cyc = TICK_40_CYC;
    unique case (res)
      HSIT_RES_40NS:  cyc = TICK_40_CYC;
      HSIT_RES_80NS:  cyc = TICK_80_CYC;
      HSIT_RES_160NS: cyc = TICK_160_CYC;
      HSIT_RES_1US:   cyc = TICK_1000_CYC;
    endcase
    return cyc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]        sync_sel_q;
  logic              frame_seen_q;
  logic              sync_loss_flag_q;
  logic              sync_locked_prev_q;
  logic [7:0]        irq_ctl_q;
  logic              tx_port_irq_pending_q;
  logic [NUM_RX-1:0] rx_irq_pending_q;
  logic [7:0]        ts_cfg_q;
  logic [EVT_NUM-1:0] evt_sts_q;
  logic [EVT_NUM-1:0] evt_mask_q;
  logic [7:0]        tick_cnt_q;
  logic              tick_q;
  logic              capture_armed_q;
  logic              capture_q;
  logic              ready_prev_q;
  logic [7:0]        rdata_q;

  logic              sync_enabled;
  logic              sync_locked_flag;
  logic              loss_event;
  logic              wr_fwd_mode;
  logic              wr_irq_ctl;
  logic              wr_ts_cfg;
  logic              wr_evt_sts;
  logic              wr_evt_mask;
  logic              rd_forward_sync_status;
  logic [4:0]        src_pending;
  logic [4:0]        src_enable;
  logic              global_pending;
  logic              fs_edge;
  logic              point_event;
  logic [EVT_NUM-1:0] evt_set;
  logic [7:0]        forward_sync_status_rd;
  logic [7:0]        irq_sts_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_fwd_mode = reg_wr_i && reg_addr_i == ADDR_FWD_MODE;
  assign wr_irq_ctl  = reg_wr_i && reg_addr_i == ADDR_IRQ_CTL;
  assign wr_ts_cfg   = reg_wr_i && reg_addr_i == ADDR_TS_CFG;
  assign wr_evt_sts  = reg_wr_i && reg_addr_i == ADDR_EVT_STS;
  assign wr_evt_mask = reg_wr_i && reg_addr_i == ADDR_EVT_MASK;
  assign rd_forward_sync_status  = reg_rd_i && reg_addr_i == ADDR_FORWARD_SYNC_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding mode select
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_sel_q <= RST_SYNC_SEL;
    end else if (wr_fwd_mode) begin
      sync_sel_q <= reg_wdata_i[1:0];
    end
  end

  assign sync_enabled          = sync_sel_q != 2'b00;
  assign sync_forward_select_o = sync_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding synchronisation status

  // Lock is the engine's own state, forced low while sync is off
  assign sync_locked_flag = sync_enabled & fwd_sync_ok_i;

  // Remember one good synchronised frame; forget it when sync is turned off
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_seen_q <= 1'b0;
    end else if (!sync_enabled) begin
      frame_seen_q <= 1'b0;
    end else if (fwd_frame_sent_i) begin
      frame_seen_q <= 1'b1;
    end
  end

  // Loss counts only after a frame got out; losses before that are noise
  assign loss_event = sync_enabled & frame_seen_q & fwd_sync_lost_i;

  // Loss flag clears on read of its register, set wins
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_loss_flag_q <= 1'b0;
    end else begin
      sync_loss_flag_q <= sticky(sync_loss_flag_q, loss_event, rd_forward_sync_status);
    end
  end

  // Lock history for the lock-gained hub event
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_locked_prev_q <= 1'b0;
    end else begin
      sync_locked_prev_q <= sync_locked_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables; bits 6 and 5 cannot be written
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_ctl_q <= RST_BYTE;
    end else if (wr_irq_ctl) begin
      irq_ctl_q <= reg_wdata_i & IRQ_CTL_WMASK;
    end
  end

  // Transmit port source, cleared by a read of its event register
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_port_irq_pending_q <= 1'b0;
    end else begin
      tx_port_irq_pending_q <= sticky(tx_port_irq_pending_q, tx_port_irq_i,
                                      tx_port_event_read_i);
    end
  end

  // Receive port sources, each cleared by a read of its own event registers
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq_pending_q <= '0;
    end else begin
      for (int p = 0; p < NUM_RX; p++) begin
        rx_irq_pending_q[p] <= sticky(rx_irq_pending_q[p], rx_port_irq_i[p],
                                      rx_port_event_read_i[p]);
      end
    end
  end

  // Global pending does not look at the global enable
  assign src_pending    = {tx_port_irq_pending_q, rx_irq_pending_q[3:0]};
  assign src_enable     = irq_ctl_q[IRQ_TX_BIT:0];
  assign global_pending = |(src_pending & src_enable)
                        | |(evt_sts_q & evt_mask_q);

  // Level output to the controller
  assign irq_o = irq_ctl_q[IRQ_GLOBAL_BIT] & global_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp configuration; bits 7 and 2 cannot be written
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ts_cfg_q <= RST_BYTE;
    end else if (wr_ts_cfg) begin
      ts_cfg_q <= reg_wdata_i & TS_CFG_WMASK;
    end
  end

  assign stamp_free_run_select_o = ts_cfg_q[TS_FREE_BIT];
  assign stamp_capture_point_o   = ts_cfg_q[TS_POINT_BIT];

  // Frame-sync pin with selectable active edge
  hsit_fs_edge u_fs_edge (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n),
    .frame_sync_i (frame_sync_i),
    .edge_sel_i   (ts_cfg_q[TS_EDGE_BIT]),
    .fs_level_o   (),
    .fs_edge_o    (fs_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp tick; a new resolution applies at once to the running count, which is not restarted
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= tick_cycles(hsit_res_t'(ts_cfg_q[TS_RES_LSB+:2])) - 8'h01) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q     <= 1'b0;
    end
  end

  assign stamp_tick_o = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Capture trigger
  assign point_event = ts_cfg_q[TS_POINT_BIT] ? frame_start_i : line_start_i;

  // Frame-sync mode arms on the active edge and fires at the next capture
  // point; free-run fires at every capture point without arming
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_armed_q <= 1'b0;
      capture_q       <= 1'b0;
    end else if (ts_cfg_q[TS_FREE_BIT]) begin
      capture_armed_q <= 1'b0;
      capture_q       <= point_event;
    end else begin
      capture_armed_q <= fs_edge | (capture_armed_q & ~point_event);
      capture_q       <= capture_armed_q & point_event;
    end
  end

  assign stamp_capture_o = capture_q;

  // Ready: early once every port has a stamp, otherwise the normal flag
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stamp_ready_o <= 1'b0;
    end else if (ts_cfg_q[TS_EARLY_BIT]) begin
      stamp_ready_o <= &stamp_port_avail_i;
    end else begin
      stamp_ready_o <= stamp_normal_ready_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ready_prev_q <= 1'b0;
    end else begin
      ready_prev_q <= stamp_ready_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hub events: sticky, cleared by writing one, set wins
  assign evt_set[EVT_LOSS_BIT]  = loss_event;
  assign evt_set[EVT_LOCK_BIT]  = sync_locked_flag & ~sync_locked_prev_q;
  assign evt_set[EVT_READY_BIT] = stamp_ready_o & ~ready_prev_q;
  assign evt_set[EVT_FS_BIT]    = fs_edge;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_sts_q <= '0;
    end else begin
      for (int e = 0; e < EVT_NUM; e++) begin
        evt_sts_q[e] <= sticky(evt_sts_q[e], evt_set[e],
                               wr_evt_sts & reg_wdata_i[e]);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask_q <= '0;
    end else if (wr_evt_mask) begin
      evt_mask_q <= reg_wdata_i[EVT_NUM-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped and reserved read zero
  always_comb begin
    forward_sync_status_rd                 = 8'h00;
    forward_sync_status_rd[FWD_LOCKED_BIT] = sync_locked_flag;
    forward_sync_status_rd[FWD_LOSS_BIT]   = sync_loss_flag_q;
  end

  always_comb begin
    irq_sts_rd                    = 8'h00;
    irq_sts_rd[IRQ_TX_BIT:0]      = src_pending;
    irq_sts_rd[IRQ_GLOBAL_BIT]    = global_pending;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_FORWARD_SYNC_STATUS:  rdata_q <= forward_sync_status_rd;
        ADDR_IRQ_CTL:  rdata_q <= irq_ctl_q;
        ADDR_IRQ_STS:  rdata_q <= irq_sts_rd;
        ADDR_TS_CFG:   rdata_q <= ts_cfg_q;
        ADDR_FWD_MODE: rdata_q <= {6'h00, sync_sel_q};
        ADDR_EVT_STS:  rdata_q <= {4'h0, evt_sts_q};
        ADDR_EVT_MASK: rdata_q <= {4'h0, evt_mask_q};
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // hsit_regs

`default_nettype wire

/* verification/hsit_host_model.sv */
// Host controller model that counts interrupt assertions on its input
`timescale 1ns/1ps
`default_nettype none

module hsit_host_model (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic irq_i,
  output logic [7:0] irq_count_o
);
  logic irq_q;

  // Level line: one service per rising level, a held line is not counted twice
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q       <= 1'b0;
      irq_count_o <= 8'h00;
    end else begin
      irq_q <= irq_i;
      if (irq_i && !irq_q) begin
        irq_count_o <= irq_count_o + 8'h01;
      end
    end
  end
endmodule // hsit_host_model

`default_nettype wire

/* verification/hsit_regs_bench.sv */
// Self-checking bench for the hub register bank
`timescale 1ns/1ps
`default_nettype none

module hsit_regs_bench;
  import hsit_pkg::*;
  logic       core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, frame_sync_i, stamp_normal_ready_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, icnt;
  logic [3:0] rx_port_irq_i, rx_port_event_read_i, stamp_port_avail_i;
  logic [1:0] sync_forward_select_o;
  logic       irq_o, fwd_frame_sent_i, fwd_sync_ok_i, fwd_sync_lost_i, tx_port_irq_i;
  logic       tx_port_event_read_i, line_start_i, frame_start_i, stamp_tick_o;
  logic       stamp_capture_o, stamp_ready_o, stamp_free_run_select_o, stamp_capture_point_o;
  logic [13:0] pv;
  int         n_mismatch, checks_done;
  logic [7:0] tick_n [4];

  // Pulse inputs: 0-3 rx event, 4 tx event, 5-9 their clears, 10 sent, 11 lost
  assign {frame_start_i, line_start_i, fwd_sync_lost_i, fwd_frame_sent_i,
          tx_port_event_read_i, rx_port_event_read_i, tx_port_irq_i, rx_port_irq_i} = pv;

  hsit_regs #(.NUM_RX(4)) u_dut (.*);
  hsit_host_model u_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .irq_i(irq_o),
                          .irq_count_o(icnt));

  // 200 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask

  task automatic pulse(input int k);
    @(posedge core_clk_i);
    pv[k] <= 1'b1;
    @(posedge core_clk_i);
    pv <= '0;
    #1;
  endtask

  task automatic cap(input int k, input logic e);
    pulse(k);
    chk({7'h00, stamp_capture_o}, {7'h00, e});
  endtask

  // Pin change needs the synchroniser delay before it counts
  task automatic fsd(input logic v);
    @(posedge core_clk_i);
    frame_sync_i <= v;
    repeat (6) @(posedge core_clk_i);
  endtask

  task automatic setin(input logic [3:0] a, input logic n, input logic e);
    @(posedge core_clk_i);
    stamp_port_avail_i   <= a;
    stamp_normal_ready_i <= n;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({7'h00, stamp_ready_o}, {7'h00, e});
  endtask

  // Second tick to third tick, so the partial period after the config write is not timed
  task automatic tick_per(input logic [1:0] c, input logic [7:0] n);
    int k;
    wr(ADDR_TS_CFG, {2'b00, c, 4'h0});
    for (int t = 0; t < 3; t++) begin
      k = 0;
      do begin
        @(posedge core_clk_i);
        #1;
        k++;
      end while (!stamp_tick_o && k < 500);
    end
    chk(8'(k), n);
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, frame_sync_i, stamp_normal_ready_i, fwd_sync_ok_i} = '0;
    {reg_addr_i, reg_wdata_i, stamp_port_avail_i, pv} = '0;
    tick_n = '{TICK_40_CYC, TICK_80_CYC, TICK_160_CYC, TICK_1000_CYC};
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < 4; i++) rd(ADDR_FORWARD_SYNC_STATUS + 8'(i), RST_BYTE);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, 8'h00);
    wr(ADDR_IRQ_CTL, 8'hFF);
    rd(ADDR_IRQ_CTL, IRQ_CTL_WMASK);
    wr(ADDR_TS_CFG, 8'hFF);
    rd(ADDR_TS_CFG, TS_CFG_WMASK);
    wr(ADDR_FORWARD_SYNC_STATUS, 8'hFF);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h00);
    wr(ADDR_TS_CFG, 8'h00);
    // Each source: foreign enable, own enable without global, full enable, clear
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_IRQ_CTL, 8'h80 | 8'(1 << ((k + 1) % 5)));
      pulse(k);
      rd(ADDR_IRQ_STS, 8'(1 << k));
      wr(ADDR_IRQ_CTL, 8'(1 << k));
      rd(ADDR_IRQ_STS, 8'h80 | 8'(1 << k));
      chk({7'h00, irq_o}, 8'h00);
      wr(ADDR_IRQ_CTL, 8'h80 | 8'(1 << k));
      chk({7'h00, irq_o}, 8'h01);
      pulse(k + 5);
      rd(ADDR_IRQ_STS, 8'h00);
      chk({7'h00, irq_o}, 8'h00);
    end
    chk(icnt, 8'h05);
    wr(ADDR_IRQ_CTL, 8'h00);
    // Forwarding status: off, lock only, loss before and after a sent frame
    @(posedge core_clk_i);
    fwd_sync_ok_i <= 1'b1;
    pulse(11);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h00);
    wr(ADDR_FWD_MODE, 8'h01);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h01);
    pulse(11);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h01);
    pulse(10);
    pulse(11);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h05);
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h01);
    for (int c = 2; c < 4; c++) begin
      wr(ADDR_FWD_MODE, 8'(c));
      rd(ADDR_FORWARD_SYNC_STATUS, 8'h01);
    end
    rd(ADDR_FWD_MODE, 8'h03);
    @(posedge core_clk_i);
    fwd_sync_ok_i <= 1'b0;
    rd(ADDR_FORWARD_SYNC_STATUS, 8'h00);
    for (int c = 0; c < 4; c++) tick_per(2'(c), tick_n[c]);
    // Capture points in free-run and frame-sync modes, both pin polarities
    wr(ADDR_TS_CFG, 8'h02);
    cap(12, 1'b1);
    cap(13, 1'b0);
    wr(ADDR_TS_CFG, 8'h03);
    cap(13, 1'b1);
    cap(12, 1'b0);
    wr(ADDR_TS_CFG, 8'h00);
    cap(12, 1'b0);
    fsd(1'b1);
    cap(12, 1'b1);
    fsd(1'b0);
    cap(12, 1'b0);
    wr(ADDR_TS_CFG, 8'h40);
    fsd(1'b1);
    cap(12, 1'b0);
    fsd(1'b0);
    cap(12, 1'b1);
    // Ready reporting, early and normal
    wr(ADDR_TS_CFG, 8'h08);
    setin(4'hF, 1'b0, 1'b1);
    setin(4'h7, 1'b0, 1'b0);
    wr(ADDR_TS_CFG, 8'h00);
    setin(4'hF, 1'b1, 1'b1);
    setin(4'hF, 1'b0, 1'b0);
    // Hub events: loss, lock, ready rise and pin edge all seen by now
    rd(ADDR_EVT_STS, 8'h0F);
    wr(ADDR_EVT_MASK, 8'h04);
    rd(ADDR_IRQ_STS, 8'h80);
    wr(ADDR_EVT_STS, 8'h04);
    rd(ADDR_IRQ_STS, 8'h00);
    rd(ADDR_EVT_STS, 8'h0B);
    rd(ADDR_EVT_MASK, 8'h04);
    final_report();
  end

  // Watchdog well beyond the thousand or so cycles the sequence needs
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule // hsit_regs_bench

`default_nettype wire

/* verification/hsit_regs_monitor.sv */
// Checker for the hub register bank, watching only its ports
`timescale 1ns/1ps
`default_nettype none

module hsit_regs_monitor
  import hsit_pkg::*;
#(
  parameter int NUM_RX = 4
) (
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              fwd_sync_lost_i,
  input wire logic [1:0]        sync_forward_select_o,
  input wire logic              irq_o,
  input wire logic              line_start_i,
  input wire logic              frame_start_i,
  input wire logic [NUM_RX-1:0] stamp_port_avail_i,
  input wire logic              stamp_capture_o,
  input wire logic              stamp_ready_o,
  input wire logic              stamp_free_run_select_o,
  input wire logic              stamp_capture_point_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [7:0] en_q;
  logic [7:0] cfg_q;
  logic       rd_fwd;

  // Shadow of the writable enables and config, so the checks need no hierarchy
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q  <= 8'h00;
      cfg_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_CTL) begin
      en_q <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == ADDR_TS_CFG) begin
      cfg_q <= reg_wdata_i;
    end
  end

  assign rd_fwd = reg_rd_i && reg_addr_i == ADDR_FORWARD_SYNC_STATUS;

  // Bits that no register implements; unmapped addresses read all zero
  function automatic logic [7:0] rsv(input logic [7:0] a);
    case (a)
      ADDR_FORWARD_SYNC_STATUS:  return 8'hFA;
      ADDR_IRQ_CTL:  return 8'h60;
      ADDR_IRQ_STS:  return 8'h60;
      ADDR_TS_CFG:   return 8'h84;
      ADDR_FWD_MODE: return 8'hFC;
      ADDR_EVT_STS:  return 8'hF0;
      ADDR_EVT_MASK: return 8'hF0;
      default:       return 8'hFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_bits_zero: assert property
    (reg_rd_i |=> (reg_rdata_o & rsv($past(reg_addr_i))) == 8'h00)
    else $error("reserved or unmapped bits read nonzero");
  a_lock_when_off: assert property
    (rd_fwd && sync_forward_select_o == 2'h0 |=> !reg_rdata_o[FWD_LOCKED_BIT])
    else $error("lock bit set with forwarding sync off");
  a_loss_read_clear: assert property
    (rd_fwd && !fwd_sync_lost_i ##1 !fwd_sync_lost_i ##1 rd_fwd && !fwd_sync_lost_i
     |=> !reg_rdata_o[FWD_LOSS_BIT])
    else $error("loss flag survived a read");
  a_irq_needs_enable: assert property (irq_o |-> en_q[IRQ_GLOBAL_BIT])
    else $error("interrupt without global enable");
  a_irq_follows_pending: assert property
    (reg_rd_i && reg_addr_i == ADDR_IRQ_STS && en_q[IRQ_GLOBAL_BIT]
     |=> reg_rdata_o[IRQ_GLOBAL_BIT] == $past(irq_o))
    else $error("interrupt line disagrees with global pending");
  a_early_ready: assert property
    (cfg_q[TS_EARLY_BIT] && &stamp_port_avail_i |=> stamp_ready_o)
    else $error("ready missing with all timestamps available");
  a_capture_free_run: assert property
    (stamp_free_run_select_o && (stamp_capture_point_o ? frame_start_i : line_start_i)
     |=> stamp_capture_o)
    else $error("free-run capture missed its point event");
  a_cfg_echo: assert property
    (reg_wr_i && reg_addr_i == ADDR_TS_CFG |=> stamp_free_run_select_o ==
     $past(reg_wdata_i[TS_FREE_BIT]) && stamp_capture_point_o == $past(reg_wdata_i[0]))
    else $error("capture config outputs do not follow the write");
  a_select_echo: assert property
    (reg_wr_i && reg_addr_i == ADDR_FWD_MODE
     |=> sync_forward_select_o == $past(reg_wdata_i[1:0]))
    else $error("sync select output does not follow the write");

  c_irq_raised: cover property ($rose(irq_o));
  c_capture: cover property (stamp_capture_o);
  c_loss_read: cover property (rd_fwd ##1 reg_rdata_o[FWD_LOSS_BIT]);

endmodule // hsit_regs_monitor

bind hsit_regs hsit_regs_monitor #(.NUM_RX(NUM_RX)) u_monitor (.*);

`default_nettype wire
